// ### design/lfps_supervisor.v
// Function
// [RQ1] Backlight on at any press, off after 15 minutes without press.
// [RQ2] Detect indicator shows call, delay, extension, pending or loop failure.
// [RQ3] Tuning completes and channel becomes operational within 2 seconds.
// [RQ4] Full sensitivity and hold only after 30 seconds running after tuning.
// [RQ5] Out of range or abrupt change over 25% enters fail-safe at once.
// [RQ6] Low fault tag for drop or short; high tag for rise or open.
// [RQ7] Fail-safe and failure message stay while the fault persists.
// [RQ8] After reset, failed channel retunes and resumes if loop is good.
// [RQ9] Fail-safe holds call output asserted in presence or pulse mode.
// [RQ10] Failure starts three-flash bursts each second until manual reset.
// [RQ11] Self-healed fault clears message but bursts remain latched.
// [RQ12] Failure counter counts each failure, cleared on reset, viewable.
// [RQ13] All four switches held 5 s restore defaults, countdown shown.
// [RQ14] Releasing any switch before countdown end aborts restore.
// [RQ15] Any two switches pressed together light every display segment.
// [RQ16] Restore sets disconnect type and all options to off.
// [RQ17] Channel button held 3 s resets the channel.
// [RQ18] Sensitivity or frequency change also resets the channel.
// [RQ19] Switches are debounced before gestures are evaluated.
// [RQ20] Range check is evaluated on every completed measurement.
`timescale 1ns/10ps
`default_nettype none
`include "lfps_consts.vh"

module lfps_supervisor #(
  parameter TICK_CYC     = `LFPS_TICK_CYC,
  parameter BACKLIGHT_MS = `LFPS_BACKLIGHT_MS,
  parameter TUNE_MS      = `LFPS_TUNE_MS,
  parameter FULL_MS      = `LFPS_FULL_SENS_MS,
  parameter RESTORE_MS   = `LFPS_RESTORE_MS,
  parameter HOLD_MS      = `LFPS_CHANNEL_SELECT_BUTTON_HOLD_MS,
  parameter BURST_MS     = `LFPS_BURST_PERIOD_MS,
  parameter FLASH_MS     = `LFPS_FLASH_MS,
  parameter DEB_MS       = `LFPS_DEBOUNCE_MS,
  parameter IND_W        = 16
) (
  input  wire              sys_clk,
  input  wire              rst,
  input  wire [3:0]        switch_raw,
  input  wire              channel_select_button,
  input  wire              setting_changed,
  input  wire              meas_done,
  input  wire [IND_W-1:0]  meas_ind,
  input  wire [IND_W-1:0]  ind_min,
  input  wire [IND_W-1:0]  ind_max,
  input  wire              loop_short,
  input  wire              loop_open,
  input  wire              presence_mode,
  input  wire              detect_call,
  input  wire              delay_timing,
  input  wire              ext_timing,
  input  wire              pending,
  input  wire [7:0]        addr,
  input  wire [7:0]        wdata,
  input  wire              wr,
  input  wire              rd,
  output reg  [7:0]        rdata,
  output reg               backlight,
  output reg               operational,
  output reg               full_sens,
  output reg               fail_safe,
  output reg               loop_fail_msg,
  output reg               low_fault_tag,
  output reg               high_fault_tag,
  output reg               call_out,
  output reg               detect_led,
  output reg  [`LFPS_FCNT_W-1:0] fail_count,
  output reg  [2:0]        restore_countdown,
  output reg               restore_active,
  output reg               defaults_load,
  output reg               disconnect_type,
  output reg               display_test
);

  localparam ST_TUNE = 2'd0;
  localparam ST_WARM = 2'd1;
  localparam ST_RUN  = 2'd2;

  localparam ADDR_STATUS = 8'h00;
  localparam ADDR_FCNT   = 8'h01;
  localparam ADDR_OPTS   = 8'h02;

  function [31:0] inc_sat;
    input [31:0] v;
    begin
      inc_sat = (v == 32'hffffffff) ? v : v + 32'd1;
    end
  endfunction

  function [2:0] popc4;
    input [3:0] v;
    begin
      popc4 = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} + {2'b00, v[3]};
    end
  endfunction

  // 1 ms tick divider
  reg  [31:0] div_q;
  wire        tick = (div_q == TICK_CYC - 1);
  always @(posedge sys_clk) begin
    if (rst || tick)
      div_q <= 32'h0;
    else
      div_q <= div_q + 32'h1;
  end

  // Debounce switches and channel button
  reg [4:0]  sw_sync_q;
  reg [4:0]  sw_q;
  reg [31:0] deb_cnt_q [0:4];
  wire [4:0] raw_all = {channel_select_button, switch_raw};
  integer i;
  always @(posedge sys_clk) begin
    sw_sync_q <= raw_all;
    for (i = 0; i < 5; i = i + 1) begin
      if (rst) begin
        sw_q[i]      <= 1'b0;
        deb_cnt_q[i] <= 32'h0;
      end else if (sw_sync_q[i] == sw_q[i]) begin
        deb_cnt_q[i] <= 32'h0;
      end else if (tick) begin
        if (deb_cnt_q[i] >= DEB_MS - 1) begin // RQ19
          sw_q[i]      <= sw_sync_q[i];
          deb_cnt_q[i] <= 32'h0;
        end else begin
          deb_cnt_q[i] <= deb_cnt_q[i] + 32'h1;
        end
      end
    end
  end

  reg  [4:0] sw_prev_q;
  wire       any_press = |(sw_q & ~sw_prev_q);
  always @(posedge sys_clk) begin
    if (rst)
      sw_prev_q <= 5'h0;
    else
      sw_prev_q <= sw_q;
  end

  // Backlight
  reg [31:0] bl_cnt_q;
  always @(posedge sys_clk) begin
    if (rst) begin
      bl_cnt_q  <= 32'h0;
      backlight <= 1'b0;
    end else if (any_press) begin
      bl_cnt_q  <= 32'h0;
      backlight <= 1'b1; // RQ1
    end else if (backlight && tick) begin
      if (bl_cnt_q >= BACKLIGHT_MS - 1)
        backlight <= 1'b0; // RQ1
      else
        bl_cnt_q <= bl_cnt_q + 32'h1;
    end
  end

  // Factory restore and display test
  wire       all_four = (sw_q[3:0] == 4'hf);
  reg [31:0] rst_cnt_q;
  always @(posedge sys_clk) begin
    if (rst) begin
      rst_cnt_q      <= 32'h0;
      restore_active <= 1'b0;
      defaults_load  <= 1'b0;
      display_test   <= 1'b0;
    end else begin
      defaults_load <= 1'b0;
      display_test  <= (popc4(sw_q[3:0]) == 3'd2); // RQ15
      if (!all_four) begin
        rst_cnt_q      <= 32'h0; // RQ14
        restore_active <= 1'b0;
      end else if (restore_active || rst_cnt_q == 32'h0) begin
        restore_active <= 1'b1;
        if (tick) begin
          if (rst_cnt_q >= RESTORE_MS - 1) begin
            defaults_load  <= 1'b1; // RQ13
            restore_active <= 1'b0;
          end
          rst_cnt_q <= rst_cnt_q + 32'h1;
        end
      end
    end
  end

  // Countdown in whole seconds of the hold
  localparam CD_STEP = (RESTORE_MS >= `LFPS_RESTORE_SEC) ?
                       RESTORE_MS / `LFPS_RESTORE_SEC : 1;
  wire [31:0] cd_elapsed = rst_cnt_q / CD_STEP;
  always @* begin
    restore_countdown = 3'd0;
    if (restore_active)
      restore_countdown = (cd_elapsed >= `LFPS_RESTORE_SEC - 3'd1) ? 3'd1 :
                          `LFPS_RESTORE_SEC - cd_elapsed[2:0]; // RQ13
  end

  // Channel reset: hold, setting change, restore
  reg [31:0] hold_cnt_q;
  reg        hold_fire_q;
  always @(posedge sys_clk) begin
    if (rst || !sw_q[4]) begin
      hold_cnt_q  <= 32'h0;
      hold_fire_q <= 1'b0;
    end else if (tick && !hold_fire_q) begin
      if (hold_cnt_q >= HOLD_MS - 1)
        hold_fire_q <= 1'b1;
      else
        hold_cnt_q <= hold_cnt_q + 32'h1;
    end
  end
  wire hold_reset = sw_q[4] && tick && !hold_fire_q &&
                    (hold_cnt_q >= HOLD_MS - 1); // RQ17
  wire channel_select_button_reset = hold_reset || setting_changed || defaults_load; // RQ18

  // Options: disconnect type, writable by software
  always @(posedge sys_clk) begin
    if (rst || defaults_load)
      disconnect_type <= 1'b0; // RQ16
    else if (wr && addr == ADDR_OPTS)
      disconnect_type <= wdata[0];
  end

  // Tuning sequence
  reg [1:0]  st_q;
  reg [31:0] st_cnt_q;
  always @(posedge sys_clk) begin
    if (rst || channel_select_button_reset) begin
      st_q     <= ST_TUNE; // RQ8
      st_cnt_q <= 32'h0;
    end else if (tick) begin
      case (st_q)
        ST_TUNE: begin
          if (st_cnt_q >= TUNE_MS - 1) begin
            st_q     <= ST_WARM; // RQ3
            st_cnt_q <= 32'h0;
          end else begin
            st_cnt_q <= st_cnt_q + 32'h1;
          end
        end
        ST_WARM: begin
          if (st_cnt_q >= FULL_MS - 1)
            st_q <= ST_RUN; // RQ4
          else
            st_cnt_q <= st_cnt_q + 32'h1;
        end
        ST_RUN: st_q <= ST_RUN;
        default: st_q <= ST_TUNE;
      endcase
    end
  end
  always @(posedge sys_clk) begin
    if (rst) begin
      operational <= 1'b0;
      full_sens   <= 1'b0;
    end else begin
      operational <= (st_q != ST_TUNE); // RQ3
      full_sens   <= (st_q == ST_RUN);  // RQ4
    end
  end

  // Loop fault check per measurement
  reg  [IND_W-1:0] base_q;
  reg              base_ok_q;
  wire [IND_W+6:0] m100 = {7'h0, meas_ind} * 7'd100;
  wire [IND_W+6:0] b125 = {7'h0, base_q} * 7'd125;
  wire [IND_W+6:0] b75  = {7'h0, base_q} * 7'd75;
  wire lo_now = loop_short || meas_ind < ind_min ||
                (base_ok_q && m100 < b75);  // RQ6
  wire hi_now = loop_open || meas_ind > ind_max ||
                (base_ok_q && m100 > b125); // RQ6
  wire fault_now = lo_now || hi_now;
  reg  burst_q;

  always @(posedge sys_clk) begin
    if (rst || channel_select_button_reset) begin
      fail_safe      <= 1'b0;
      loop_fail_msg  <= 1'b0;
      low_fault_tag  <= 1'b0;
      high_fault_tag <= 1'b0;
      base_ok_q      <= 1'b0;
      base_q         <= {IND_W{1'b0}};
      // Fault in a channel reset cycle still starts the bursts
      burst_q        <= !rst && meas_done && fault_now; // RQ10
      fail_count     <= `LFPS_FCNT_RST; // RQ12
    end else if (meas_done) begin // RQ20
      fail_safe      <= fault_now; // RQ5 RQ7 RQ11
      loop_fail_msg  <= fault_now; // RQ5 RQ11
      low_fault_tag  <= lo_now;
      high_fault_tag <= hi_now;
      if (fault_now) begin
        burst_q <= 1'b1; // RQ10 RQ11
        if (!fail_safe && fail_count != {`LFPS_FCNT_W{1'b1}})
          fail_count <= fail_count + 1'b1; // RQ12
      end else begin
        base_q    <= meas_ind;
        base_ok_q <= 1'b1;
      end
    end
  end

  // Burst pattern: three flashes per second
  reg [31:0] bp_cnt_q;
  always @(posedge sys_clk) begin
    if (rst || !burst_q)
      bp_cnt_q <= 32'h0;
    else if (tick)
      bp_cnt_q <= (bp_cnt_q >= BURST_MS - 1) ? 32'h0 : inc_sat(bp_cnt_q);
  end
  wire [31:0] slot  = bp_cnt_q / FLASH_MS;
  wire        flash = burst_q && slot < 2 * `LFPS_FLASH_COUNT &&
                      !slot[0]; // RQ10

  // Call and detect indicator
  always @(posedge sys_clk) begin
    if (rst) begin
      call_out   <= 1'b0;
      detect_led <= 1'b0;
    end else begin
      call_out <= fail_safe || (operational && detect_call); // RQ9
      if (burst_q)
        detect_led <= flash; // RQ10
      else
        detect_led <= detect_call || delay_timing || ext_timing ||
                      pending || fail_safe; // RQ2
    end
  end

  // Register read port
  always @(posedge sys_clk) begin
    if (rst)
      rdata <= 8'h00;
    else if (rd) begin
      case (addr)
        ADDR_STATUS: rdata <= {presence_mode, burst_q, high_fault_tag,
                               low_fault_tag, fail_safe, full_sens,
                               operational, backlight};
        ADDR_FCNT:   rdata <= fail_count; // RQ12
        ADDR_OPTS:   rdata <= {7'h00, disconnect_type};
        default:     rdata <= 8'h00;
      endcase
    end else
      rdata <= 8'h00;
  end

endmodule // lfps_supervisor

`default_nettype wire

// ### common/lfps_consts.vh
`ifndef LFPS_CONSTS_VH
`define LFPS_CONSTS_VH

// Clock rate
`define LFPS_CLK_HZ          250000000
// Tick divider: 1 ms system tick
`define LFPS_TICK_NS         1000000
`define LFPS_CLK_NS          4
`define LFPS_TICK_CYC        (`LFPS_TICK_NS / `LFPS_CLK_NS)
// Times in milliseconds, except LFPS_RESTORE_SEC in seconds and LFPS_FLASH_COUNT, a count
`define LFPS_BACKLIGHT_MS    900000
`define LFPS_TUNE_MS         2000
`define LFPS_FULL_SENS_MS    30000
`define LFPS_RESTORE_MS      5000
`define LFPS_RESTORE_SEC     3'd5
`define LFPS_CHANNEL_SELECT_BUTTON_HOLD_MS    3000
`define LFPS_BURST_PERIOD_MS 1000
`define LFPS_FLASH_MS        100
`define LFPS_FLASH_COUNT     3
`define LFPS_DEBOUNCE_MS     20
// Fault threshold in percent
`define LFPS_FAULT_PCT       25
// Counter width
`define LFPS_FCNT_W          8
// Reset values
`define LFPS_FCNT_RST        8'h00

`endif

// ### sim/lfps_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module lfps_ctrl_model (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic call_out,
  output var  logic call_seen_q
);
  // Controller input latches any call it samples
  always @(posedge sys_clk) begin
    if (rst)
      call_seen_q <= 1'b0;
    else if (call_out)
      call_seen_q <= 1'b1;
  end
endmodule // lfps_ctrl_model
`default_nettype wire

// ### sim/lfps_supervisor_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "lfps_consts.vh"
module lfps_chk #(
  parameter TICK_CYC     = 2,
  parameter BACKLIGHT_MS = 60,
  parameter TUNE_MS      = 4,
  parameter DEB_MS       = 2
) (
  input wire logic                    sys_clk,
  input wire logic                    rst,
  input wire logic [3:0]              switch_raw,
  input wire logic                    channel_select_button,
  input wire logic [7:0]              addr,
  input wire logic                    rd,
  input wire logic [7:0]              rdata,
  input wire logic                    backlight,
  input wire logic                    operational,
  input wire logic                    full_sens,
  input wire logic                    fail_safe,
  input wire logic                    loop_fail_msg,
  input wire logic                    low_fault_tag,
  input wire logic                    high_fault_tag,
  input wire logic                    call_out,
  input wire logic [`LFPS_FCNT_W-1:0] fail_count,
  input wire logic [2:0]              restore_countdown,
  input wire logic                    defaults_load,
  input wire logic                    disconnect_type
);
  localparam int BL_LIM   = (BACKLIGHT_MS + DEB_MS + 2) * TICK_CYC;
  localparam int TUNE_LIM = (TUNE_MS + 2) * TICK_CYC;
  logic [31:0] idle_q;
  // Cycles since any button was last down
  always @(posedge sys_clk) begin
    if (rst || switch_raw != 4'h0 || channel_select_button)
      idle_q <= 32'h0;
    else if (idle_q < BL_LIM)
      idle_q <= idle_q + 32'h1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_op; $fell(rst) |-> ##[1:TUNE_LIM] operational; endproperty
  a_op: assert property (p_op) else $error("tuning too slow");
  property p_full; full_sens |-> operational; endproperty
  a_full: assert property (p_full) else $error("full before tuned");
  property p_call; fail_safe |=> call_out; endproperty
  a_call: assert property (p_call) else $error("no call in fail-safe");
  property p_msg; fail_safe |-> loop_fail_msg; endproperty
  a_msg: assert property (p_msg) else $error("message missing");
  property p_tag; fail_safe |-> low_fault_tag != high_fault_tag; endproperty
  a_tag: assert property (p_tag) else $error("fault type wrong");
  property p_cnt;
    $changed(fail_count) |->
      (fail_safe && fail_count == $past(fail_count) + 8'h01) ||
      fail_count == 8'h00;
  endproperty
  a_cnt: assert property (p_cnt) else $error("count step wrong");
  property p_bl; idle_q == BL_LIM |-> !backlight; endproperty
  a_bl: assert property (p_bl) else $error("backlight stuck on");
  property p_ld; defaults_load |-> switch_raw == 4'hf; endproperty
  a_ld: assert property (p_ld) else $error("restore not held");
  property p_dis; defaults_load |=> !disconnect_type; endproperty
  a_dis: assert property (p_dis) else $error("type not cleared");
  property p_cd; restore_countdown <= 3'h5; endproperty
  a_cd: assert property (p_cd) else $error("countdown range");
  property p_rd;
    $past(rd) && $past(addr) == 8'h01 |-> rdata == $past(fail_count);
  endproperty
  a_rd: assert property (p_rd) else $error("count read wrong");
endmodule // lfps_chk
bind lfps_supervisor lfps_chk #(.TICK_CYC(TICK_CYC),
  .BACKLIGHT_MS(BACKLIGHT_MS), .TUNE_MS(TUNE_MS), .DEB_MS(DEB_MS)) u_chk (
  .sys_clk, .rst, .switch_raw, .channel_select_button, .addr, .rd, .rdata,
  .backlight, .operational, .full_sens, .fail_safe, .loop_fail_msg,
  .low_fault_tag, .high_fault_tag, .call_out, .fail_count,
  .restore_countdown, .defaults_load, .disconnect_type);
`default_nettype wire

// ### sim/lfps_supervisor_test.sv
`timescale 1ns/10ps
`default_nettype none
module lfps_supervisor_test;
  logic        sys_clk, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic        channel_select_button = 1'b0, setting_changed = 1'b0;
  logic        meas_done = 1'b0, loop_short = 1'b0, loop_open = 1'b0;
  logic        presence_mode = 1'b1, detect_call = 1'b0, pending = 1'b0;
  logic        delay_timing = 1'b0, ext_timing = 1'b0, call_seen;
  logic [3:0]  switch_raw = 4'h0;
  logic [15:0] meas_ind = 16'h0, ind_min = 16'h0064, ind_max = 16'h0fa0;
  logic [7:0]  addr = 8'h0, wdata = 8'h0, rdata, fail_count;
  logic [2:0]  restore_countdown;
  logic        backlight, operational, full_sens, fail_safe, loop_fail_msg;
  logic        low_fault_tag, high_fault_tag, call_out, detect_led;
  logic        restore_active, defaults_load, disconnect_type, display_test;
  int          error_cnt = 0, check_count = 0, n;
  localparam int T_TICK = 2, T_BL = 60, T_TUNE = 4, T_FULL = 8;
  localparam int T_REST = 10, T_HOLD = 6, T_BURST = 10, T_FLASH = 1;
  localparam int T_DEB = 2;
  wire [7:0]   flags = {3'h0, fail_safe, loop_fail_msg, low_fault_tag,
                        high_fault_tag, call_out};
  lfps_supervisor #(.TICK_CYC(T_TICK), .BACKLIGHT_MS(T_BL),
    .TUNE_MS(T_TUNE), .FULL_MS(T_FULL), .RESTORE_MS(T_REST),
    .HOLD_MS(T_HOLD), .BURST_MS(T_BURST), .FLASH_MS(T_FLASH),
    .DEB_MS(T_DEB)) dut (
    .sys_clk, .rst, .switch_raw, .channel_select_button, .setting_changed,
    .meas_done, .meas_ind, .ind_min, .ind_max, .loop_short, .loop_open,
    .presence_mode, .detect_call, .delay_timing, .ext_timing, .pending,
    .addr, .wdata, .wr, .rd, .rdata, .backlight, .operational, .full_sens,
    .fail_safe, .loop_fail_msg, .low_fault_tag, .high_fault_tag, .call_out,
    .detect_led, .fail_count, .restore_countdown, .restore_active,
    .defaults_load, .disconnect_type, .display_test);
  lfps_ctrl_model ctrl (.sys_clk, .rst, .call_out, .call_seen_q(call_seen));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, e);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(posedge sys_clk);
    chk("rdata", e, rdata);
  endtask
  task automatic meas(input logic [15:0] v, input logic s, o);
    @(posedge sys_clk);
    meas_done <= 1'b1;
    meas_ind <= v;
    loop_short <= s;
    loop_open <= o;
    @(posedge sys_clk);
    meas_done <= 1'b0;
    cyc(3);
  endtask
  // Indicator rises over one burst period
  task automatic count_rises(output int k);
    logic p;
    k = 0;
    p = detect_led;
    repeat (20) begin
      @(posedge sys_clk);
      if (detect_led === 1'b1 && p === 1'b0)
        k++;
      p = detect_led;
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    cyc(12);
    rst <= 1'b0;
    cyc(14);
    chk("operational", 8'h01, {7'h0, operational});
    chk("full_sens", 8'h00, {7'h0, full_sens});
    cyc(26);
    chk("full_sens", 8'h01, {7'h0, full_sens});
    wr_reg(8'h02, 8'h01);
    rchk(8'h02, 8'h01);
    rchk(8'h7f, 8'h00);
    chk("call_seen", 8'h00, {7'h0, call_seen});
    meas(16'h03e8, 1'b0, 1'b0);
    meas(16'h0258, 1'b0, 1'b0);
    chk("flags", 8'h1d, flags);
    chk("call_seen", 8'h01, {7'h0, call_seen});
    meas(16'h0258, 1'b0, 1'b0);
    chk("flags", 8'h1d, flags);
    meas(16'h03e8, 1'b0, 1'b0);
    chk("flags", 8'h00, flags);
    count_rises(n);
    chk("bursts", 8'h03, n[7:0]);
    meas(16'h03e8, 1'b0, 1'b1);
    chk("flags", 8'h1b, flags);
    meas(16'h03e8, 1'b0, 1'b0);
    rchk(8'h01, 8'h02);
    channel_select_button <= 1'b1;
    cyc(30);
    channel_select_button <= 1'b0;
    cyc(30);
    rchk(8'h01, 8'h00);
    count_rises(n);
    chk("bursts", 8'h00, n[7:0]);
    for (int i = 0; i < 4; i++) begin
      detect_call <= (i == 0);
      delay_timing <= (i == 1);
      ext_timing <= (i == 2);
      pending <= (i == 3);
      cyc(3);
      chk("detect_led", 8'h01, {7'h0, detect_led});
    end
    detect_call <= 1'b0;
    delay_timing <= 1'b0;
    ext_timing <= 1'b0;
    pending <= 1'b0;
    presence_mode <= 1'b0;
    meas(16'h03e8, 1'b0, 1'b0);
    meas(16'h0578, 1'b0, 1'b0);
    chk("flags", 8'h1b, flags);
    meas(16'h03e8, 1'b1, 1'b0);
    chk("flags", 8'h1d, flags);
    meas(16'h03e8, 1'b0, 1'b0);
    @(posedge sys_clk);
    setting_changed <= 1'b1;
    @(posedge sys_clk);
    setting_changed <= 1'b0;
    cyc(4);
    rchk(8'h01, 8'h00);
    ind_max <= 16'h0320;
    meas(16'h03e8, 1'b0, 1'b0);
    chk("flags", 8'h1b, flags);
    ind_max <= 16'h0fa0;
    ind_min <= 16'h07d0;
    meas(16'h03e8, 1'b0, 1'b0);
    chk("flags", 8'h1d, flags);
    ind_min <= 16'h0064;
    meas(16'h03e8, 1'b0, 1'b0);
    chk("flags", 8'h00, flags);
    switch_raw <= 4'h5;
    cyc(12);
    chk("display_test", 8'h01, {7'h0, display_test});
    switch_raw <= 4'hf;
    cyc(12);
    chk("countdown", 8'h01, {7'h0, |restore_countdown});
    switch_raw <= 4'h0;
    cyc(40);
    rchk(8'h02, 8'h01);
    switch_raw <= 4'hf;
    cyc(40);
    switch_raw <= 4'h0;
    cyc(10);
    rchk(8'h02, 8'h00);
    chk("backlight", 8'h01, {7'h0, backlight});
    cyc(160);
    chk("backlight", 8'h00, {7'h0, backlight});
    rchk(8'h00, 8'h06);
    tally_and_finish();
  end
  initial begin
    cyc(5000);
    error_cnt++;
    tally_and_finish();
  end
endmodule // lfps_supervisor_test
`default_nettype wire
